// [hdl/lss_regs.vh]
// register offsets, field layout and encodings of the shadow steering block
`ifndef LSS_REGS_VH
`define LSS_REGS_VH

// ********************************************
// configuration byte offsets
// ********************************************
`define LSS_OFS_C0000 8'h91
`define LSS_OFS_C8000 8'h92
`define LSS_OFS_D0000 8'h93

// ********************************************
// field positions and reset values
// ********************************************
`define LSS_LO_LSB 0
`define LSS_LO_MSB 1
`define LSS_HI_LSB 4
`define LSS_HI_MSB 5
`define LSS_ATTR_RST 8'h00
`define LSS_ATTR_WMASK 8'h33

// ********************************************
// attribute encodings, bit 0 reads, bit 1 writes
// ********************************************
`define LSS_ATTR_LINK 2'h0
`define LSS_ATTR_RDONLY 2'h1
`define LSS_ATTR_WRONLY 2'h2
`define LSS_ATTR_DRAM 2'h3
`define LSS_RD_BIT 0
`define LSS_WR_BIT 1

// ********************************************
// window decode: 16 KB segments, address bits
// ********************************************
`define LSS_SEG_SH 14
`define LSS_TOP_SH 20
`define LSS_WIN_TAG 3'h6
`define LSS_SEG_CNT 3'h6

`endif

// [hdl/lss_seg_decode.v]
// segment decoder: window hit, attribute pick and memory or link steering
`timescale 1ns/1ps
module lss_seg_decode #(
  parameter AW = 32
) (
  input wire [AW-1:0] i_addr,
  input wire i_wr,
  input wire [11:0] i_attr_map,
  output reg o_hit,
  output reg [1:0] o_attr,
  output reg o_to_mem,
  output reg o_to_link
);
`include "lss_regs.vh"

  // ********************************************
  // window and segment index
  // ********************************************
  wire [AW-1:0] top_bits;
  wire [2:0] tag;
  wire [2:0] idx;

  assign top_bits = i_addr >> `LSS_TOP_SH;
  assign tag = i_addr[19:17];
  assign idx = i_addr[16:14];

  always @* begin
    o_hit = (top_bits == {AW{1'b0}}) && (tag == `LSS_WIN_TAG) &&
            (idx < `LSS_SEG_CNT);
    case (idx)
      3'h0: o_attr = i_attr_map[1:0];
      3'h1: o_attr = i_attr_map[3:2];
      3'h2: o_attr = i_attr_map[5:4];
      3'h3: o_attr = i_attr_map[7:6];
      3'h4: o_attr = i_attr_map[9:8];
      3'h5: o_attr = i_attr_map[11:10];
      default: o_attr = `LSS_ATTR_LINK;
    endcase
    // 00 link, 01 reads dram, 10 writes dram, 11 all dram
    if (i_wr)
      o_to_mem = o_hit & o_attr[`LSS_WR_BIT];
    else
      o_to_mem = o_hit & o_attr[`LSS_RD_BIT];
    o_to_link = o_hit & ~o_to_mem;
  end

endmodule

// [hdl/lss_steer.v]
// shadow window steering: attribute registers and per-requester routing
`timescale 1ns/1ps
module lss_steer #(
  parameter AW = 32
) (
  input wire i_sys_clk,
  input wire i_srst,
  input wire i_cfg_wr,
  input wire i_cfg_rd,
  input wire [7:0] i_cfg_addr,
  input wire [7:0] i_cfg_wdata,
  output wire [7:0] o_cfg_rdata,
  output wire o_cfg_rvalid,
  input wire i_host_vld,
  input wire i_host_wr,
  input wire [AW-1:0] i_host_addr,
  output wire o_host_vld,
  output wire o_host_wr,
  output wire [AW-1:0] o_host_addr,
  output wire o_host_hit,
  output wire o_host_to_mem,
  output wire o_host_to_link,
  input wire i_init_vld,
  input wire i_init_wr,
  input wire [AW-1:0] i_init_addr,
  output wire o_init_vld,
  output wire o_init_wr,
  output wire [AW-1:0] o_init_addr,
  output wire o_init_hit,
  output wire o_init_to_mem,
  output wire o_init_to_link,
  output wire o_init_unsafe
);
`include "lss_regs.vh"

  // ********************************************
  // attribute registers
  // ********************************************
  reg [7:0] shadow_attr_c0000_c7fff_r;
  reg [7:0] shadow_attr_c8000_cffff_r;
  reg [7:0] shadow_attr_d0000_d7fff_r;
  reg [7:0] cfg_rdata_r;
  reg [7:0] cfg_rdata_nxt;
  reg cfg_rvalid_r;
  wire [7:0] wdata_masked;

  // reserved bits never stored, so they always read back zero
  assign wdata_masked = i_cfg_wdata & `LSS_ATTR_WMASK;

  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      shadow_attr_c0000_c7fff_r <= `LSS_ATTR_RST;
      shadow_attr_c8000_cffff_r <= `LSS_ATTR_RST;
      shadow_attr_d0000_d7fff_r <= `LSS_ATTR_RST;
    end else if (i_cfg_wr) begin
      case (i_cfg_addr)
        `LSS_OFS_C0000: shadow_attr_c0000_c7fff_r <= wdata_masked;
        `LSS_OFS_C8000: shadow_attr_c8000_cffff_r <= wdata_masked;
        `LSS_OFS_D0000: shadow_attr_d0000_d7fff_r <= wdata_masked;
        default: ;
      endcase
    end
  end

  // ********************************************
  // configuration read-back
  // ********************************************
  always @* begin
    case (i_cfg_addr)
      `LSS_OFS_C0000: cfg_rdata_nxt = shadow_attr_c0000_c7fff_r;
      `LSS_OFS_C8000: cfg_rdata_nxt = shadow_attr_c8000_cffff_r;
      `LSS_OFS_D0000: cfg_rdata_nxt = shadow_attr_d0000_d7fff_r;
      default: cfg_rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      cfg_rdata_r <= 8'h00;
      cfg_rvalid_r <= 1'b0;
    end else begin
      cfg_rvalid_r <= i_cfg_rd;
      if (i_cfg_rd)
        cfg_rdata_r <= cfg_rdata_nxt;
    end
  end

  assign o_cfg_rdata = cfg_rdata_r;
  assign o_cfg_rvalid = cfg_rvalid_r;

  // ********************************************
  // segment attribute map, one pair per 16 KB
  // ********************************************
  wire [11:0] attr_map;

  assign attr_map[1:0] =
    shadow_attr_c0000_c7fff_r[`LSS_LO_MSB:`LSS_LO_LSB];
  assign attr_map[3:2] =
    shadow_attr_c0000_c7fff_r[`LSS_HI_MSB:`LSS_HI_LSB];
  assign attr_map[5:4] =
    shadow_attr_c8000_cffff_r[`LSS_LO_MSB:`LSS_LO_LSB];
  assign attr_map[7:6] =
    shadow_attr_c8000_cffff_r[`LSS_HI_MSB:`LSS_HI_LSB];
  assign attr_map[9:8] =
    shadow_attr_d0000_d7fff_r[`LSS_LO_MSB:`LSS_LO_LSB];
  assign attr_map[11:10] =
    shadow_attr_d0000_d7fff_r[`LSS_HI_MSB:`LSS_HI_LSB];

  // ********************************************
  // requesters: index 0 host, index 1 initiator
  // ********************************************
  wire [1:0] req_vld;
  wire [1:0] req_wr;
  wire [2*AW-1:0] req_addr;

  assign req_vld = {i_init_vld, i_host_vld};
  assign req_wr = {i_init_wr, i_host_wr};
  assign req_addr = {i_init_addr, i_host_addr};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_req
      wire hit;
      wire [1:0] attr;
      wire to_mem;
      wire to_link;
      reg vld_r;
      reg wr_r;
      reg [AW-1:0] addr_r;
      reg hit_r;
      reg to_mem_r;
      reg to_link_r;
      reg unsafe_r;

      // same decoder and same map for both, no requester bias
      lss_seg_decode #(
        .AW(AW)
      ) u_dec (
        .i_addr(req_addr[g*AW +: AW]),
        .i_wr(req_wr[g]),
        .i_attr_map(attr_map),
        .o_hit(hit),
        .o_attr(attr),
        .o_to_mem(to_mem),
        .o_to_link(to_link)
      );

      // idle cycles clear the routing, so nothing stale is seen
      always @(posedge i_sys_clk) begin
        if (i_srst) begin
          vld_r <= 1'b0;
          wr_r <= 1'b0;
          addr_r <= {AW{1'b0}};
          hit_r <= 1'b0;
          to_mem_r <= 1'b0;
          to_link_r <= 1'b0;
          unsafe_r <= 1'b0;
        end else begin
          vld_r <= req_vld[g];
          wr_r <= req_wr[g];
          addr_r <= req_addr[g*AW +: AW];
          hit_r <= req_vld[g] & hit;
          to_mem_r <= req_vld[g] & to_mem;
          to_link_r <= req_vld[g] & to_link;
          // a hit segment not fully in dram (any code but 11) may hang the hub: flag it
          unsafe_r <= req_vld[g] & hit &
                      (attr != `LSS_ATTR_DRAM);
        end
      end
    end
  endgenerate

  // ********************************************
  // registered outputs
  // ********************************************
  assign o_host_vld = gen_req[0].vld_r;
  assign o_host_wr = gen_req[0].wr_r;
  assign o_host_addr = gen_req[0].addr_r;
  assign o_host_hit = gen_req[0].hit_r;
  assign o_host_to_mem = gen_req[0].to_mem_r;
  assign o_host_to_link = gen_req[0].to_link_r;

  assign o_init_vld = gen_req[1].vld_r;
  assign o_init_wr = gen_req[1].wr_r;
  assign o_init_addr = gen_req[1].addr_r;
  assign o_init_hit = gen_req[1].hit_r;
  assign o_init_to_mem = gen_req[1].to_mem_r;
  assign o_init_to_link = gen_req[1].to_link_r;
  // host unsafe flag is computed alike but left internal
  assign o_init_unsafe = gen_req[1].unsafe_r;

endmodule

// [sim/lss_req_model.sv]
// requester model: one host or initiator request port
`timescale 1ns/1ps
module lss_req_model (
  input wire i_sys_clk,
  input wire i_go,
  input wire i_wr,
  input wire [31:0] i_addr,
  output reg o_vld = 1'h0,
  output reg o_wr = 1'h0,
  output reg [31:0] o_addr = 32'h0
);
  // idle lines toggle so a stale request never looks held
  always @(negedge i_sys_clk) begin
    o_vld <= i_go;
    o_wr <= i_go ? i_wr : ~o_wr;
    o_addr <= i_go ? i_addr : ~o_addr;
  end
endmodule

// [sim/lss_steer_sva.sv]
// port checker for the shadow steering block
`timescale 1ns/1ps
module lss_steer_chk #(
  parameter AW = 32
) (
  input wire i_sys_clk,
  input wire i_srst,
  input wire i_cfg_rd,
  input wire o_cfg_rvalid,
  input wire [7:0] o_cfg_rdata,
  input wire i_host_vld,
  input wire [AW-1:0] i_host_addr,
  input wire o_host_vld,
  input wire o_host_hit,
  input wire o_host_to_mem,
  input wire o_host_to_link,
  input wire o_init_hit,
  input wire o_init_to_mem,
  input wire o_init_unsafe
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  sequence s_rd_ans;
    ##1 o_cfg_rvalid;
  endsequence
  property p_rd; i_cfg_rd |-> s_rd_ans; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_rv1; !i_cfg_rd |=> !o_cfg_rvalid; endproperty
  a_rv1: assert property (p_rv1) else $error("stray read valid");
  property p_rsv; o_cfg_rvalid |-> (o_cfg_rdata & 8'hCC) == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_hold; !o_cfg_rvalid |-> $stable(o_cfg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_vld; i_host_vld |=> o_host_vld; endproperty
  a_vld: assert property (p_vld) else $error("host valid lost");
  property p_idle;
    !i_host_vld |=> !(o_host_hit | o_host_to_mem | o_host_to_link);
  endproperty
  a_idle: assert property (p_idle) else $error("idle steer");
  property p_out;
    i_host_vld &&
      (i_host_addr < 32'h000C0000 || i_host_addr > 32'h000D7FFF)
      |=> !o_host_hit;
  endproperty
  a_out: assert property (p_out) else $error("hit outside window");
  property p_one; o_host_hit |-> o_host_to_mem ^ o_host_to_link; endproperty
  a_one: assert property (p_one) else $error("steer not one way");
  property p_uns; o_init_hit && !o_init_to_mem |-> o_init_unsafe; endproperty
  a_uns: assert property (p_uns) else $error("unsafe not flagged");
endmodule
bind lss_steer lss_steer_chk #(.AW(AW)) u_chk (.i_sys_clk(i_sys_clk),
  .i_srst(i_srst), .i_cfg_rd(i_cfg_rd), .o_cfg_rvalid(o_cfg_rvalid),
  .o_cfg_rdata(o_cfg_rdata), .i_host_vld(i_host_vld),
  .i_host_addr(i_host_addr), .o_host_vld(o_host_vld),
  .o_host_hit(o_host_hit), .o_host_to_mem(o_host_to_mem),
  .o_host_to_link(o_host_to_link), .o_init_hit(o_init_hit),
  .o_init_to_mem(o_init_to_mem), .o_init_unsafe(o_init_unsafe));

// [sim/tb_lss_steer.sv]
// self-checking bench for the shadow steering block
`timescale 1ns/1ps
module tb_lss_steer;
  reg clk = 1'h0;
  reg srst = 1'h1;
  reg cwr = 1'h0;
  reg crd = 1'h0;
  reg [7:0] cad = 8'h00;
  reg [7:0] cwd = 8'h00;
  reg go = 1'h0;
  reg rwr = 1'h0;
  reg [31:0] rad = 32'h0;
  reg [1:0] at;
  reg mem;
  integer failures = 0;
  integer comparisons = 0;
  integer a, s, k;
  wire [7:0] rdata;
  wire rv, hv, hw, iv, iw, ov, oh, om, ol, jv, jh, jm, jl, un;
  wire [31:0] ha, ia;
  wire hwo, iwo;
  wire [31:0] hao, iao;
  always #2.5 clk = ~clk;
  lss_req_model u_host (.i_sys_clk(clk), .i_go(go), .i_wr(rwr),
    .i_addr(rad), .o_vld(hv), .o_wr(hw), .o_addr(ha));
  lss_req_model u_init (.i_sys_clk(clk), .i_go(go), .i_wr(rwr),
    .i_addr(rad), .o_vld(iv), .o_wr(iw), .o_addr(ia));
  lss_steer #(.AW(32)) dut_u (.i_sys_clk(clk), .i_srst(srst),
    .i_cfg_wr(cwr), .i_cfg_rd(crd), .i_cfg_addr(cad), .i_cfg_wdata(cwd),
    .o_cfg_rdata(rdata), .o_cfg_rvalid(rv), .i_host_vld(hv),
    .i_host_wr(hw), .i_host_addr(ha), .o_host_vld(ov), .o_host_wr(hwo),
    .o_host_addr(hao), .o_host_hit(oh), .o_host_to_mem(om),
    .o_host_to_link(ol), .i_init_vld(iv), .i_init_wr(iw),
    .i_init_addr(ia), .o_init_vld(jv), .o_init_wr(iwo), .o_init_addr(iao),
    .o_init_hit(jh), .o_init_to_mem(jm), .o_init_to_link(jl),
    .o_init_unsafe(un));
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        failures = failures + 1;
      end
    end
  endtask
  task cfg(input w, input [7:0] ofs, input [7:0] d, input [7:0] exp);
    begin
      @(negedge clk);
      cwr = w;
      crd = ~w;
      cad = ofs;
      cwd = d;
      @(negedge clk);
      cwr = 1'h0;
      crd = 1'h0;
      if (!w) chk("rvalid", 8'h01, {7'h00, rv});
      if (!w) chk(".rdata", exp, rdata);
    end
  endtask
  // exp: bit0 memory, bit1 link, bit2 hit, bit3 unsafe
  task req(input w, input [31:0] ad, input [7:0] exp);
    begin
      @(posedge clk);
      go <= 1'h1;
      rwr <= w;
      rad <= ad;
      @(posedge clk);
      go <= 1'h0;
      @(negedge clk);
      chk("host", (exp & 8'h07) | 8'h08, {4'h0, ov, oh, ol, om});
      chk("init", exp | 8'h10, {3'h0, jv, un, jh, jl, jm});
      chk("host wr", {31'h0, w}, {31'h0, hwo});
      chk("host addr", ad, hao);
      chk("init wr", {31'h0, w}, {31'h0, iwo});
      chk("init addr", ad, iao);
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'h0;
    for (k = 0; k < 4; k = k + 1) cfg(1'h0, 8'h90 + k, 8'h00, 8'h00);
    for (k = 1; k < 4; k = k + 1) begin
      cfg(1'h1, 8'h90 + k, 8'hFF, 8'h00);
      cfg(1'h0, 8'h90 + k, 8'h00, 8'h33);
    end
    // rotating fields so every segment sees every code
    for (a = 0; a < 4; a = a + 1) begin
      for (k = 0; k < 3; k = k + 1)
        cfg(1'h1, 8'h91 + k, {2'h0, 2'(a + 2 * k + 1), 2'h0,
          2'(a + 2 * k)}, 8'h00);
      for (s = 0; s < 24; s = s + 1) begin
        at = 2'(a + s / 4);
        mem = s[0] ? at[1] : at[0];
        req(s[0], 32'h000C0000 + 32'(s / 4) * 32'h00004000 +
          (s[1] ? 32'h00003FFF : 32'h0), {4'h0, at != 2'h3, 1'h1, ~mem,
          mem});
      end
    end
    req(1'h0, 32'h000BFFFF, 8'h00);
    req(1'h1, 32'h000D8000, 8'h00);
    // second reset mid-run: bytes must fall back to zero
    @(negedge clk);
    srst = 1'h1;
    repeat (2) @(negedge clk);
    srst = 1'h0;
    cfg(1'h0, 8'h93, 8'h00, 8'h00);
    req(1'h0, 32'h000D0000, 8'h0E);
    tally_and_finish;
  end
endmodule
